/* usb_epds_pkg.sv */
// Shared constants and types for the endpoint/descriptor status block
`default_nettype none
package usb_epds_pkg;
  // ********************
  // Timing
  // ********************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned IDLE_MS = 3;
  localparam int unsigned IDLE_CYC = (CLK_HZ / 1000) * IDLE_MS;
  localparam logic [4:0] TA_BITS = 5'h10;
  // ********************
  // Register word offsets
  // ********************
  localparam logic [4:0] OFS_EP0 = 5'h00;
  localparam logic [4:0] OFS_IFLAG = 5'h08;
  localparam logic [4:0] OFS_IEN = 5'h09;
  localparam logic [4:0] OFS_EFLAG = 5'h0a;
  localparam logic [4:0] OFS_EEN = 5'h0b;
  localparam logic [4:0] OFS_ADDR = 5'h0c;
  localparam logic [4:0] OFS_XSTAT = 5'h0d;
  localparam logic [4:0] OFS_DSEL = 5'h0e;
  localparam logic [4:0] OFS_DSTAT = 5'h0f;
  localparam logic [4:0] OFS_DBC = 5'h10;
  // ********************
  // Field positions and masks
  // ********************
  localparam int EP_HALT = 0;
  localparam int EP_IN = 1;
  localparam int EP_OUT = 2;
  localparam int DS_OWN = 7;
  localparam int DS_TOG = 6;
  localparam int DS_TCHK = 3;
  localparam int DS_BHALT = 2;
  localparam int IF_SOF = 6;
  localparam int IF_STALL = 5;
  localparam int IF_IDLE = 4;
  localparam int IF_TRN = 3;
  localparam int IF_ACT = 2;
  localparam int IF_ERR = 1;
  localparam int IF_RST = 0;
  localparam int EF_STUFF = 7;
  localparam int EF_TA = 4;
  localparam int EF_DFN8 = 3;
  localparam int EF_CRC16 = 2;
  localparam int EF_CRC5 = 1;
  localparam int EF_PID = 0;
  localparam logic [7:0] IF_MASK = 8'h7f;
  localparam logic [7:0] EF_MASK = 8'h9f;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ********************
  // Token identifiers and types
  // ********************
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_SETUP = 4'hd;
  typedef enum logic [1:0] {
    RSP_ACK = 2'h0,
    RSP_NAK = 2'h1,
    RSP_STALL = 2'h2,
    RSP_DROP = 2'h3
  } resp_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DECIDE = 2'h1,
    ST_BUSY = 2'h3
  } tok_state_t;
  typedef struct packed {
    logic [7:0][4:0] ep;
    logic [7:0][7:0] dstat;
    logic [7:0][7:0] dbc;
    logic [3:0][7:0] fifo;
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] cnt;
    logic [7:0] iflag;
    logic [7:0] ien;
    logic [7:0] eflag;
    logic [7:0] een;
    logic [6:0] addr;
    logic [2:0] sel;
    tok_state_t st;
    logic [2:0] tep;
    logic [3:0] tpid;
    logic tdata1;
    logic rv;
    resp_t rsp;
    logic [18:0] idle_cnt;
    logic [4:0] ta_cnt;
    logic ta_run;
    logic wreq;
    logic [7:0] rdata;
    logic irq;
  } state_t;
endpackage
`default_nettype wire

/* usb_epds.sv */
// Endpoint control, descriptor status and interrupt/error flags
`default_nettype none
// How it works
// [R1] IN answered only when input enabled
// [R2] Endpoint halt stalls, only when enabled
// [R3] Owner bit set locks descriptor from core
// [R4] Toggle value used only with checking on
// [R5] Toggle mismatch dropped, SETUP always accepted (code: SETUP skips only the toggle drop; halt still stalls, no owner NAKs)
// [R6] Byte count rewritten with actual count
// [R7] Received token id written into descriptor
// [R8] Software keeps descriptor bits 5:4 zero
// [R9] Start-of-frame token sets frame flag
// [R10] Sending STALL sets halt-sent flag
// [R11] Clearing done flag pops status FIFO
// [R12] Software unmasks activity after idle seen
// [R13] Error summary is read-only status
// [R14] Bus reset sets flag, clears address
// [R15] Enables gate flags into interrupt request
// [R16] Bit-stuff violation sets stuff flag
// [R17] Over 16 idle bit times sets timeout
// [R18] Token with bad CRC5 rejected, flagged
// [R19] Failed identifier check sets flag
// [R20] Error enables gate errors into summary
// [R21] Buffer halt with engine owner stalls
// [R22] 3 ms continuous idle sets idle flag
module usb_epds #(
  parameter int unsigned IDLE_CYCLES = usb_epds_pkg::IDLE_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Token path from serial engine
  input wire logic i_tok_valid,
  input wire logic [3:0] i_tok_pid,
  input wire logic [2:0] i_tok_ep,
  input wire logic i_tok_data1,
  input wire logic i_xfer_done,
  input wire logic [9:0] i_xfer_count,
  output logic o_resp_valid,
  output logic [1:0] o_resp,
  // Bus events from serial engine
  input wire logic i_sof,
  input wire logic i_usb_reset,
  input wire logic i_bus_activity,
  input wire logic i_bus_idle,
  input wire logic i_eop,
  input wire logic i_pkt_start,
  input wire logic i_bit_tick,
  input wire logic i_stuff_err,
  input wire logic i_crc5_err,
  input wire logic i_pid_err,
  input wire logic i_crc16_err,
  input wire logic i_dfn8_err,
  // Status out
  output logic [6:0] o_dev_addr,
  output logic o_usb_irq
);
  localparam logic [18:0] IDLE_LIM = 19'(IDLE_CYCLES);

  usb_epds_pkg::state_t q;
  usb_epds_pkg::state_t d;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    return a == ofs;
  endfunction

  // ********************
  // Next state
  // ********************
  always_comb begin
    logic req;
    logic wr;
    logic [4:0] a;
    logic [7:0] wd;
    logic [4:0] epc;
    logic [7:0] ds;
    logic in_tok;
    logic dir_en;
    logic push;
    logic pop;
    req = i_avs_read || i_avs_write;
    wr = i_avs_write && !q.wreq;
    a = i_avs_address;
    wd = i_avs_writedata[7:0];
    epc = q.ep[q.tep];
    ds = q.dstat[q.tep];
    in_tok = q.tpid == usb_epds_pkg::PID_IN;
    dir_en = in_tok ? epc[usb_epds_pkg::EP_IN] : epc[usb_epds_pkg::EP_OUT];
    push = 1'b0;
    pop = 1'b0;
    d = q;
    d.rv = 1'b0;
    // One wait cycle per access, then a one-cycle answer
    d.wreq = !(req && q.wreq);
    if (req && q.wreq) begin
      case (a)
        usb_epds_pkg::OFS_IFLAG: d.rdata = q.iflag;
        usb_epds_pkg::OFS_IEN: d.rdata = q.ien;
        usb_epds_pkg::OFS_EFLAG: d.rdata = q.eflag;
        usb_epds_pkg::OFS_EEN: d.rdata = q.een;
        usb_epds_pkg::OFS_ADDR: d.rdata = {1'b0, q.addr};
        usb_epds_pkg::OFS_XSTAT: d.rdata = (q.cnt != 3'h0) ? q.fifo[q.rp] : 8'h00;
        usb_epds_pkg::OFS_DSEL: d.rdata = {5'h00, q.sel};
        usb_epds_pkg::OFS_DSTAT: d.rdata = q.dstat[q.sel];
        usb_epds_pkg::OFS_DBC: d.rdata = q.dbc[q.sel];
        default: d.rdata = (a[4:3] == 2'h0) ? {3'h0, q.ep[a[2:0]]} : 8'h00;
      endcase
    end
    // ********************
    // Software writes
    // ********************
    if (wr) begin
      if (a[4:3] == usb_epds_pkg::OFS_EP0[4:3]) begin
        d.ep[a[2:0]] = wd[4:0];
      end
      case (a)
        usb_epds_pkg::OFS_IFLAG: d.iflag = q.iflag & wd & usb_epds_pkg::IF_MASK;
        usb_epds_pkg::OFS_IEN: d.ien = wd & usb_epds_pkg::IF_MASK;
        usb_epds_pkg::OFS_EFLAG: d.eflag = q.eflag & wd;
        usb_epds_pkg::OFS_EEN: d.een = wd & usb_epds_pkg::EF_MASK;
        usb_epds_pkg::OFS_ADDR: d.addr = wd[6:0];
        usb_epds_pkg::OFS_DSEL: d.sel = wd[2:0];
        usb_epds_pkg::OFS_DSTAT: begin
          if (!q.dstat[q.sel][usb_epds_pkg::DS_OWN]) begin
            d.dstat[q.sel] = wd; // [R3]
          end
        end
        usb_epds_pkg::OFS_DBC: begin
          if (!q.dstat[q.sel][usb_epds_pkg::DS_OWN]) begin
            d.dbc[q.sel] = wd; // [R3]
          end
        end
        default: ;
      endcase
      if (hit(a, usb_epds_pkg::OFS_IFLAG) && !wd[usb_epds_pkg::IF_TRN]) begin
        pop = q.cnt != 3'h0; // [R11]
      end
    end
    // ********************
    // Token handling
    // ********************
    case (q.st)
      usb_epds_pkg::ST_IDLE: begin
        if (i_tok_valid && !i_crc5_err) begin // [R18]
          d.tep = i_tok_ep;
          d.tpid = i_tok_pid;
          d.tdata1 = i_tok_data1;
          d.st = usb_epds_pkg::ST_DECIDE;
        end
      end
      usb_epds_pkg::ST_DECIDE: begin
        d.st = usb_epds_pkg::ST_IDLE;
        // Disabled direction gets no handshake at all
        if (dir_en) begin // [R1]
          d.rv = 1'b1;
          if (epc[usb_epds_pkg::EP_HALT] ||
              (ds[usb_epds_pkg::DS_OWN] && ds[usb_epds_pkg::DS_BHALT])) begin // [R2] [R21]
            d.rsp = usb_epds_pkg::RSP_STALL;
            d.iflag[usb_epds_pkg::IF_STALL] = 1'b1; // [R10]
          end else if (!ds[usb_epds_pkg::DS_OWN]) begin
            d.rsp = usb_epds_pkg::RSP_NAK;
          end else if (!in_tok && ds[usb_epds_pkg::DS_TCHK] &&
                       (ds[usb_epds_pkg::DS_TOG] != q.tdata1) &&
                       (q.tpid != usb_epds_pkg::PID_SETUP)) begin // [R4] [R5]
            d.rsp = usb_epds_pkg::RSP_DROP;
          end else begin
            d.rsp = usb_epds_pkg::RSP_ACK;
            d.st = usb_epds_pkg::ST_BUSY;
          end
        end
      end
      usb_epds_pkg::ST_BUSY: begin
        if (i_xfer_done) begin
          d.dstat[q.tep] = {1'b0, 1'b0, q.tpid, i_xfer_count[9:8]}; // [R6] [R7]
          d.dbc[q.tep] = i_xfer_count[7:0]; // [R6]
          d.st = usb_epds_pkg::ST_IDLE;
          // A full status FIFO loses the entry; software must keep up
          if (q.cnt != 3'h4) begin
            push = 1'b1;
            d.fifo[q.wp] = {1'b0, 1'b0, q.tep, in_tok, 2'h0};
            d.wp = q.wp + 2'h1;
          end
        end
      end
      default: d.st = usb_epds_pkg::ST_IDLE;
    endcase
    if (pop) begin
      d.rp = q.rp + 2'h1;
    end
    d.cnt = q.cnt + {2'h0, push} - {2'h0, pop};
    // ********************
    // Bus events; sets win over software clears
    // ********************
    if (i_sof) begin
      d.iflag[usb_epds_pkg::IF_SOF] = 1'b1; // [R9]
    end
    if (i_bus_activity) begin
      d.iflag[usb_epds_pkg::IF_ACT] = 1'b1;
    end
    if (i_usb_reset) begin
      d.iflag[usb_epds_pkg::IF_RST] = 1'b1; // [R14]
      d.addr = 7'h00; // [R14]
    end
    d.iflag[usb_epds_pkg::IF_TRN] = d.cnt != 3'h0;
    if (!i_bus_idle) begin
      d.idle_cnt = 19'h00000;
    end else if (q.idle_cnt < IDLE_LIM) begin
      d.idle_cnt = q.idle_cnt + 19'h00001;
      if (q.idle_cnt == IDLE_LIM - 19'h00001) begin
        d.iflag[usb_epds_pkg::IF_IDLE] = 1'b1; // [R22]
      end
    end
    if (i_eop) begin
      d.ta_run = 1'b1;
      d.ta_cnt = 5'h00;
    end else if (i_pkt_start) begin
      d.ta_run = 1'b0;
    end else if (q.ta_run && i_bit_tick) begin
      if (q.ta_cnt == usb_epds_pkg::TA_BITS) begin
        d.eflag[usb_epds_pkg::EF_TA] = 1'b1; // [R17]
        d.ta_run = 1'b0;
      end else begin
        d.ta_cnt = q.ta_cnt + 5'h01;
      end
    end
    if (i_stuff_err) begin
      d.eflag[usb_epds_pkg::EF_STUFF] = 1'b1; // [R16]
    end
    if (i_crc5_err) begin
      d.eflag[usb_epds_pkg::EF_CRC5] = 1'b1; // [R18]
    end
    if (i_pid_err) begin
      d.eflag[usb_epds_pkg::EF_PID] = 1'b1; // [R19]
    end
    if (i_crc16_err) begin
      d.eflag[usb_epds_pkg::EF_CRC16] = 1'b1;
    end
    if (i_dfn8_err) begin
      d.eflag[usb_epds_pkg::EF_DFN8] = 1'b1;
    end
    // Summary follows enabled errors only; writes never touch it
    d.iflag[usb_epds_pkg::IF_ERR] = |(q.eflag & q.een); // [R13] [R20]
    d.irq = |(q.iflag & q.ien); // [R15]
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
      q.wreq <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_avs_readdata = {24'h000000, q.rdata};
  assign o_avs_waitrequest = q.wreq;
  assign o_resp_valid = q.rv;
  assign o_resp = q.rsp;
  assign o_dev_addr = q.addr;
  assign o_usb_irq = q.irq;

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  logic dir_en_chk;
  logic err_any;
  logic irq_any;
  assign dir_en_chk = (q.tpid == usb_epds_pkg::PID_IN) ?
    q.ep[q.tep][usb_epds_pkg::EP_IN] : q.ep[q.tep][usb_epds_pkg::EP_OUT];
  assign err_any = |(q.eflag & q.een);
  assign irq_any = |(q.iflag & q.ien);

  sequence s_decide_halt;
    q.st == usb_epds_pkg::ST_DECIDE && dir_en_chk && q.ep[q.tep][usb_epds_pkg::EP_HALT];
  endsequence
  sequence s_stall_out;
    o_resp_valid && o_resp == usb_epds_pkg::RSP_STALL && q.iflag[usb_epds_pkg::IF_STALL];
  endsequence

  property p_halt_stall;
    s_decide_halt |=> s_stall_out;
  endproperty
  a_halt_stall: assert property (p_halt_stall) else $error("halted endpoint not stalled"); // [R2]

  property p_dir_off;
    q.st == usb_epds_pkg::ST_DECIDE && !dir_en_chk |=> !o_resp_valid;
  endproperty
  a_dir_off: assert property (p_dir_off) else $error("disabled direction answered"); // [R1]

  property p_bus_reset;
    i_usb_reset |=> o_dev_addr == 7'h00 && q.iflag[usb_epds_pkg::IF_RST];
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset not handled"); // [R14]

  property p_sof;
    i_sof |=> q.iflag[usb_epds_pkg::IF_SOF];
  endproperty
  a_sof: assert property (p_sof) else $error("frame flag not set"); // [R9]

  property p_summary;
    ##1 q.iflag[usb_epds_pkg::IF_ERR] == $past(err_any);
  endproperty
  a_summary: assert property (p_summary) else $error("error summary wrong"); // [R20]

  property p_irq;
    ##1 o_usb_irq == $past(irq_any);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gating wrong"); // [R15]

  property p_crc5;
    q.st == usb_epds_pkg::ST_IDLE && i_tok_valid && i_crc5_err
      |=> q.st == usb_epds_pkg::ST_IDLE && q.eflag[usb_epds_pkg::EF_CRC5] ##1 !o_resp_valid;
  endproperty
  a_crc5: assert property (p_crc5) else $error("bad token not rejected"); // [R18]

  property p_writeback;
    q.st == usb_epds_pkg::ST_BUSY && i_xfer_done
      |=> q.dstat[$past(q.tep)][5:2] == $past(q.tpid) && !q.dstat[$past(q.tep)][7]
        && q.dbc[$past(q.tep)] == $past(i_xfer_count[7:0]);
  endproperty
  a_writeback: assert property (p_writeback) else $error("descriptor not returned"); // [R7]

  property p_wait;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");

  property p_stuff;
    i_stuff_err |=> q.eflag[usb_epds_pkg::EF_STUFF];
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuff error not flagged"); // [R16]

  property p_idle;
    i_bus_idle && q.idle_cnt == IDLE_LIM - 19'h00001 |=> q.iflag[usb_epds_pkg::IF_IDLE];
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag not set"); // [R22]
endmodule
`default_nettype wire

/* usb_epds_eng_model.sv */
// Serial engine model: tokens, transfer ends and bus events
`default_nettype none
module usb_epds_eng_model (
  // Clock
  input wire logic i_sys_clk,
  // Handshake decision from the block
  input wire logic i_resp_valid,
  input wire logic [1:0] i_resp,
  // Token path
  output logic o_tok_valid,
  output logic [3:0] o_tok_pid,
  output logic [2:0] o_tok_ep,
  output logic o_tok_data1,
  output logic o_xfer_done,
  output logic [9:0] o_xfer_count,
  // Events: sof rst act eop pkt tick stuff crc5 pid crc16 dfn8
  output logic [10:0] o_ev,
  output logic o_bus_idle
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_tok_valid = 1'b0;
    o_tok_pid = 4'h0;
    o_tok_ep = 3'h0;
    o_tok_data1 = 1'b0;
    o_xfer_done = 1'b0;
    o_xfer_count = 10'h000;
    o_ev = 11'h000;
    o_bus_idle = 1'b0;
  end
  // ********************
  // Event pulses, n in a row
  // ********************
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge i_sys_clk);
      o_ev <= 11'h001 << k;
    end
    @(posedge i_sys_clk);
    o_ev <= 11'h000;
  endtask
  task automatic idle(input int n);
    @(posedge i_sys_clk);
    o_bus_idle <= 1'b1;
    repeat (n) @(posedge i_sys_clk);
    o_bus_idle <= 1'b0;
  endtask
  // ********************
  // Token and its answer
  // ********************
  // Latency is fixed by the block, so the answer window is a fixed count
  task automatic tok(input logic [3:0] pid, input logic [2:0] ep, input logic d1,
                     input logic crc, output logic seen, output logic [1:0] rsp);
    seen = 1'b0;
    rsp = 2'h0;
    @(posedge i_sys_clk);
    o_tok_valid <= 1'b1;
    o_tok_pid <= pid;
    o_tok_ep <= ep;
    o_tok_data1 <= d1;
    o_ev[7] <= crc;
    @(posedge i_sys_clk);
    o_tok_valid <= 1'b0;
    o_ev[7] <= 1'b0;
    // Released lines show the inverse, not a stale copy
    o_tok_pid <= ~pid;
    o_tok_ep <= ~ep;
    o_tok_data1 <= ~d1;
    repeat (4) begin
      @(posedge i_sys_clk);
      if (i_resp_valid === 1'b1) begin
        seen = 1'b1;
        rsp = i_resp;
      end
    end
  endtask
  task automatic done(input logic [9:0] c);
    @(posedge i_sys_clk);
    o_xfer_done <= 1'b1;
    o_xfer_count <= c;
    @(posedge i_sys_clk);
    o_xfer_done <= 1'b0;
    o_xfer_count <= ~c;
  endtask
endmodule
`default_nettype wire

/* usb_epds_tb.sv */
// Testbench for the endpoint/descriptor status block
`default_nettype none
module usb_epds_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] A_IF = 5'h08;
  localparam logic [4:0] A_IE = 5'h09;
  localparam logic [4:0] A_EF = 5'h0a;
  localparam logic [4:0] A_EE = 5'h0b;
  localparam logic [4:0] A_ST = 5'h0f;
  localparam logic [2:0] X_NONE = 3'h0;
  localparam logic [2:0] X_ACK = 3'h4;
  localparam logic [2:0] X_NAK = 3'h5;
  localparam logic [2:0] X_STALL = 3'h6;
  localparam logic [2:0] X_DROP = 3'h7;
  logic clk, rst, rd, we, rv, tv, td1, xd, idl, wreq, irq, seen;
  logic [4:0] adr;
  logic [31:0] wdat, rdata;
  logic [1:0] rsp, rs;
  logic [3:0] tpid;
  logic [2:0] tep;
  logic [9:0] xc;
  logic [10:0] ev;
  logic [6:0] daddr;
  logic [7:0] epos [5] = '{8'h80, 8'h02, 8'h01, 8'h04, 8'h08};
  logic [7:0] fexp [3] = '{8'h0c, 8'h08, 8'h08};
  int fails = 0;
  int cmp_count = 0;
  usb_epds #(.IDLE_CYCLES(20)) dut_u (
    .i_sys_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(we), .i_avs_writedata(wdat), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_tok_valid(tv), .i_tok_pid(tpid), .i_tok_ep(tep),
    .i_tok_data1(td1), .i_xfer_done(xd), .i_xfer_count(xc), .o_resp_valid(rv),
    .o_resp(rsp), .i_sof(ev[0]), .i_usb_reset(ev[1]), .i_bus_activity(ev[2]),
    .i_bus_idle(idl), .i_eop(ev[3]), .i_pkt_start(ev[4]), .i_bit_tick(ev[5]),
    .i_stuff_err(ev[6]), .i_crc5_err(ev[7]), .i_pid_err(ev[8]), .i_crc16_err(ev[9]),
    .i_dfn8_err(ev[10]), .o_dev_addr(daddr), .o_usb_irq(irq));
  usb_epds_eng_model eng_u (
    .i_sys_clk(clk), .i_resp_valid(rv), .i_resp(rsp), .o_tok_valid(tv),
    .o_tok_pid(tpid), .o_tok_ep(tep), .o_tok_data1(td1), .o_xfer_done(xd),
    .o_xfer_count(xc), .o_ev(ev), .o_bus_idle(idl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********************
  // Bus tasks
  // ********************
  task automatic stop_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    rd <= 1'b0;
    we <= 1'b0;
    if (wreq !== 1'b0) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic xfer(input logic [2:0] ep, input logic [3:0] pid, input logic d1,
                      input logic [7:0] st, input logic [2:0] e, input logic [9:0] c);
    wr(5'h0e, {5'h00, ep});
    wr(A_ST, st);
    eng_u.tok(pid, ep, d1, 1'b0, seen, rs);
    chk("resp", {5'h00, seen, rs}, {5'h00, e});
    if (seen === 1'b1 && rs === 2'h0) begin
      eng_u.done(c);
    end
  endtask
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    wdat = 32'h00000000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 8; i < 12; i++) rdc(5'(i), 8'h00);
    wr(5'h1f, 8'h5a);
    rdc(5'h1f, 8'h00);
    wr(5'h0c, 8'h25);
    // Address register lands on the answer edge; look one edge later
    @(posedge clk);
    chk("addr", {1'b0, daddr}, 8'h25);
    eng_u.pulse(1, 1);
    @(posedge clk);
    chk("addr", {1'b0, daddr}, 8'h00);
    rdc(A_IF, 8'h01);
    wr(A_IE, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(A_IE, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(A_IF, 8'h00);
    eng_u.pulse(0, 1);
    rdc(A_IF, 8'h40);
    wr(A_IF, 8'h00);
    for (int k = 0; k < 5; k++) begin
      eng_u.pulse(6 + k, 1);
      rdc(A_EF, epos[k]);
      wr(A_EF, 8'h00);
    end
    eng_u.pulse(8, 1);
    rdc(A_IF, 8'h00);
    wr(A_EE, 8'h01);
    rdc(A_IF, 8'h02);
    wr(A_IF, 8'h00);
    rdc(A_IF, 8'h02);
    wr(A_EE, 8'h00);
    wr(A_EF, 8'h00);
    wr(A_IF, 8'h02);
    rdc(A_IF, 8'h00);
    wr(5'h01, 8'h01);
    xfer(3'h1, 4'h9, 1'b0, 8'h80, X_NONE, 10'h000);
    wr(5'h01, 8'h07);
    xfer(3'h1, 4'h9, 1'b0, 8'h80, X_STALL, 10'h000);
    rdc(A_IF, 8'h20);
    wr(A_IF, 8'h00);
    wr(5'h01, 8'h06);
    eng_u.tok(4'h9, 3'h1, 1'b0, 1'b1, seen, rs);
    chk("crc tok", {7'h00, seen}, 8'h00);
    rdc(A_EF, 8'h02);
    wr(A_EF, 8'h00);
    xfer(3'h1, 4'h9, 1'b0, 8'h80, X_ACK, 10'h3ff);
    rdc(A_ST, 8'h27);
    rdc(5'h10, 8'hff);
    xfer(3'h1, 4'h9, 1'b0, 8'h00, X_NAK, 10'h000);
    xfer(3'h1, 4'h1, 1'b1, 8'h88, X_DROP, 10'h000);
    wr(A_ST, 8'h40);
    rdc(A_ST, 8'h88);
    xfer(3'h1, 4'hd, 1'b1, 8'h88, X_ACK, 10'h005);
    rdc(A_ST, 8'h34);
    xfer(3'h1, 4'h1, 1'b1, 8'h80, X_ACK, 10'h100);
    rdc(A_ST, 8'h05);
    rdc(A_IF, 8'h08);
    for (int k = 0; k < 3; k++) begin
      rdc(5'h0d, fexp[k]);
      wr(A_IF, 8'hf7);
    end
    rdc(5'h0d, 8'h00);
    rdc(A_IF, 8'h00);
    wr(5'h02, 8'h06);
    xfer(3'h2, 4'h9, 1'b0, 8'h84, X_STALL, 10'h000);
    rdc(A_ST, 8'h84);
    wr(A_IF, 8'h00);
    eng_u.pulse(3, 1);
    eng_u.pulse(5, 16);
    rdc(A_EF, 8'h00);
    eng_u.pulse(5, 1);
    rdc(A_EF, 8'h10);
    eng_u.idle(15);
    rdc(A_IF, 8'h00);
    eng_u.idle(25);
    rdc(A_IF, 8'h10);
    // Activity unmasked only once idle has been seen
    eng_u.pulse(2, 1);
    wr(A_IE, 8'h04);
    repeat (2) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
    rdc(A_IF, 8'h14);
    stop_test();
  end
endmodule
`default_nettype wire
